/* hw/nph_pkg.sv */
// package: header layout, flag codes, register map and limits of the packet header controller
package nph_pkg;
  localparam int NPH_HDR_BYTES = 12;
  localparam logic [3:0] NPH_HDR_LAST = 4'hb;
  localparam logic [7:0] NPH_FLG_NEEDS_CSUM = 8'h01;
  localparam logic [7:0] NPH_FLG_DATA_VALID = 8'h02;
  localparam logic [7:0] NPH_FLG_RSC_INFO = 8'h04;
  localparam logic [7:0] NPH_GSO_NONE = 8'h00;
  localparam logic [7:0] NPH_GSO_TCPV4 = 8'h01;
  localparam logic [7:0] NPH_GSO_UDP = 8'h03;
  localparam logic [7:0] NPH_GSO_TCPV6 = 8'h04;
  localparam logic [7:0] NPH_GSO_ECN = 8'h80;
  localparam logic [15:0] NPH_NUMBUF_TX = 16'h0000;
  localparam logic [15:0] NPH_NUMBUF_ONE = 16'h0001;
  localparam logic [16:0] NPH_MAX_STD = 17'd1514;
  localparam logic [16:0] NPH_MAX_LRO = 17'd65550;
  // register byte offsets
  localparam logic [5:0] NPH_REG_FEAT = 6'h00;
  localparam logic [5:0] NPH_REG_TXF = 6'h04;
  localparam logic [5:0] NPH_REG_TXG = 6'h08;
  localparam logic [5:0] NPH_REG_TXC = 6'h0c;
  localparam logic [5:0] NPH_REG_CMD = 6'h10;
  localparam logic [5:0] NPH_REG_RXA = 6'h14;
  localparam logic [5:0] NPH_REG_RXB = 6'h18;
  localparam logic [5:0] NPH_REG_RXC = 6'h1c;
  localparam logic [5:0] NPH_REG_RXS = 6'h20;
  // command bits
  localparam int NPH_CMD_GO = 0;
  localparam int NPH_CMD_RXCLR = 1;
  localparam int NPH_CMD_TXCLR = 2;
  localparam logic [8:0] NPH_FEAT_RST = 9'h000;

  typedef struct packed {
    logic [15:0] num_buffers;
    logic [15:0] csum_offset;
    logic [15:0] csum_start;
    logic [15:0] gso_size;
    logic [15:0] hdr_len;
    logic [7:0] gso_type;
    logic [7:0] flags;
  } nph_hdr_s;

  typedef struct packed {
    logic rsc_ext;
    logic mrg_rxbuf;
    logic guest_lro;
    logic guest_csum;
    logic host_ecn;
    logic host_ufo;
    logic host_tso6;
    logic host_tso4;
    logic csum;
  } nph_feat_s;

  typedef enum logic [2:0] {
    NPH_TX_IDLE = 3'b001,
    NPH_TX_HDR = 3'b010,
    NPH_TX_PAY = 3'b100
  } nph_tx_e;

  typedef enum logic [1:0] {
    NPH_RX_HDR = 2'b01,
    NPH_RX_PAY = 2'b10
  } nph_rx_e;

  // byte i of the header in wire order (little-endian fields)
  function automatic logic [7:0] nph_hdr_byte(input nph_hdr_s h, input logic [3:0] i);
    nph_hdr_byte = h[{i, 3'b000} +: 8];
  endfunction : nph_hdr_byte

  // ones' complement 16-bit add with end-around carry
  function automatic logic [15:0] nph_oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    nph_oc_add = s[15:0] + {15'h0000, s[16]};
  endfunction : nph_oc_add

  // byte-lane merge for bus writes
  function automatic logic [31:0] nph_lane(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int k = 0; k < 4; k++) begin
      nph_lane[8*k +: 8] = sel[k] ? nw[8*k +: 8] : old[8*k +: 8];
    end
  endfunction : nph_lane
endpackage : nph_pkg

/* hw/nph_csum.sv */
// ones' complement checksum engine over a byte stream
`timescale 1ns/1ns
module nph_csum
  import nph_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic vld_i,
  input wire logic [7:0] byte_i,
  output logic [15:0] sum_o
);
  logic [15:0] acc_q;
  logic [7:0] hi_q;
  logic odd_q;
  logic [15:0] fin;

  // big-endian words, odd tail padded with zero
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && clr_i)) begin
      acc_q <= 16'h0000;
      hi_q <= 8'h00;
      odd_q <= 1'b0;
    end else if (ce_i && vld_i) begin
      odd_q <= ~odd_q;
      if (!odd_q) hi_q <= byte_i;
      else acc_q <= nph_oc_add(acc_q, {hi_q, byte_i});
    end
  end

  assign fin = odd_q ? nph_oc_add(acc_q, {hi_q, 8'h00}) : acc_q;
  assign sum_o = ~fin;
endmodule : nph_csum

/* hw/nph_hdr_mem.sv */
// small word memory holding the last received header, registered read
`timescale 1ns/1ns
module nph_hdr_mem #(
  parameter int AW = 2,
  parameter int DW = 32
) (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] wa_i,
  input wire logic [DW-1:0] wd_i,
  input wire logic re_i,
  input wire logic [AW-1:0] ra_i,
  output logic [DW-1:0] rd_o
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) mem_q[wa_i] <= wd_i;
    if (ce_i && re_i) rd_o <= mem_q[ra_i];
  end
endmodule : nph_hdr_mem

/* hw/nph_ctrl.sv */
// driver-side packet header controller: builds transmit headers, parses receive headers
`timescale 1ns/1ns
// Function
// - each packet is framed behind a 12-byte header with fixed flag and gso codes.
// - with checksum offload, needs-checksum and start/offset locate the result field.
// - software preloads the pseudo-header sum into the packet checksum field.
// - above 1514 bytes only with a segmentation type; device cuts to gso_size.
// - ecn bit in gso_type only with host ecn and a tcp segmentation type.
// - transmit headers carry num_buffers zero; device ignores it.
// - without checksum offload the flags byte stays zero.
// - each segmentation code only with its own negotiated feature.
// - no segmentation features means gso_type is always none.
// - segmentation requires needs-checksum and a nonzero gso_size.
// - hdr_len should cover all protocol headers when segmentation is negotiated.
// - data-valid and coalescing bits never set on transmit.
// - without merged buffers post 65562 or 1526 byte receive buffers.
// - with merged buffers each posted buffer holds at least the header.
module nph_ctrl
  import nph_pkg::*;
#(
  parameter logic [16:0] MAX_STD = NPH_MAX_STD,
  parameter logic [16:0] MAX_LRO = NPH_MAX_LRO
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] pay_data_i,
  input wire logic pay_valid_i,
  input wire logic pay_last_i,
  output logic pay_ready_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  output logic rx_ready_o
);
  // bus slave
  logic pend_q, ack_q;
  logic [5:0] adr_q;
  logic [31:0] dat_q;
  logic [31:0] feat_q, txf_q, txg_q, txc_q;
  nph_feat_s feat;
  wire req = wb_cyc_i & wb_stb_i;
  wire start = req & ~pend_q & ~ack_q;
  // writes land on the acknowledge edge, while the master still holds its data
  wire wr = ack_q & req & wb_we_i;
  wire wr_cmd = wr & (adr_q == NPH_REG_CMD);
  wire cmd_go = wr_cmd & wb_sel_i[0] & wb_dat_i[NPH_CMD_GO];
  wire cmd_rxclr = wr_cmd & wb_sel_i[0] & wb_dat_i[NPH_CMD_RXCLR];
  wire cmd_txclr = wr_cmd & wb_sel_i[0] & wb_dat_i[NPH_CMD_TXCLR];
  wire [31:0] feat_wr = nph_lane(feat_q, wb_dat_i, wb_sel_i);
  assign feat = nph_feat_s'(feat_q[8:0]);

  // transmit state
  nph_tx_e tx_st_q, tx_st_d;
  logic [3:0] tx_idx_q;
  logic tx_vld_q, tx_lst_q, pay_rdy_q, tx_err_q;
  logic [7:0] tx_dat_q;
  nph_hdr_s txh;
  wire [7:0] req_flags = txf_q[7:0];
  wire [7:0] req_gso = txf_q[15:8];
  wire [7:0] gso_base = req_gso & ~NPH_GSO_ECN;
  wire need_csum = (req_flags & NPH_FLG_NEEDS_CSUM) != 8'h00;
  wire is_tcp = (gso_base == NPH_GSO_TCPV4) | (gso_base == NPH_GSO_TCPV6);
  wire e_csum = need_csum & ~feat.csum;
  wire e_gso = ((gso_base == NPH_GSO_TCPV4) & ~feat.host_tso4)
             | ((gso_base == NPH_GSO_TCPV6) & ~feat.host_tso6)
             | ((gso_base == NPH_GSO_UDP) & ~feat.host_ufo)
             | ~(is_tcp | (gso_base == NPH_GSO_UDP) | (gso_base == NPH_GSO_NONE));
  wire e_gfld = (gso_base != NPH_GSO_NONE) & (~need_csum | (txg_q[15:0] == 16'h0000));
  wire e_ecn = ((req_gso & NPH_GSO_ECN) != 8'h00) & (~feat.host_ecn | ~is_tcp);
  wire e_len = ({1'b0, txg_q[31:16]} > MAX_STD) & (gso_base == NPH_GSO_NONE);
  wire tx_bad = e_csum | e_gso | e_gfld | e_ecn | e_len;
  wire tx_fire = tx_vld_q & tx_ready_i;
  wire slot_free = ~tx_vld_q | tx_fire;
  wire pay_take = pay_rdy_q & pay_valid_i;
  wire hdr_load = (tx_st_q == NPH_TX_HDR) & slot_free;
  wire go_ok = cmd_go & (tx_st_q == NPH_TX_IDLE) & ~tx_bad;

  // only needs-checksum survives; the validity and coalescing bits never leave here
  assign txh.flags = req_flags & NPH_FLG_NEEDS_CSUM;
  assign txh.gso_type = req_gso;
  assign txh.hdr_len = txf_q[31:16];
  assign txh.gso_size = txg_q[15:0];
  // start/offset zeroed when unused so stale values never reach the device
  assign txh.csum_start = need_csum ? txc_q[15:0] : 16'h0000;
  assign txh.csum_offset = need_csum ? txc_q[31:16] : 16'h0000;
  assign txh.num_buffers = NPH_NUMBUF_TX;

  always_comb begin
    tx_st_d = tx_st_q;
    unique case (tx_st_q)
      NPH_TX_IDLE: if (go_ok) tx_st_d = NPH_TX_HDR;
      NPH_TX_HDR: if (hdr_load && tx_idx_q == NPH_HDR_LAST) tx_st_d = NPH_TX_PAY;
      NPH_TX_PAY: if (pay_take && pay_last_i) tx_st_d = NPH_TX_IDLE;
      default: tx_st_d = NPH_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_q <= NPH_TX_IDLE;
      tx_idx_q <= 4'h0;
      tx_vld_q <= 1'b0;
      tx_lst_q <= 1'b0;
      tx_dat_q <= 8'h00;
      pay_rdy_q <= 1'b0;
    end else if (ce_i) begin
      tx_st_q <= tx_st_d;
      if (hdr_load) tx_idx_q <= tx_idx_q + 4'h1;
      else if (tx_st_q == NPH_TX_IDLE) tx_idx_q <= 4'h0;
      if (hdr_load) begin
        tx_vld_q <= 1'b1;
        tx_dat_q <= nph_hdr_byte(txh, tx_idx_q);
        tx_lst_q <= 1'b0;
      end else if (pay_take) begin
        tx_vld_q <= 1'b1;
        tx_dat_q <= pay_data_i;
        tx_lst_q <= pay_last_i;
      end else if (tx_fire) begin
        tx_vld_q <= 1'b0;
      end
      // half rate: a byte is taken only into an empty output slot
      pay_rdy_q <= (tx_st_d == NPH_TX_PAY) & ~pay_take & slot_free & ~hdr_load;
    end
  end

  // receive state
  nph_rx_e rx_st_q;
  logic [3:0] rx_idx_q;
  logic [23:0] rx_asm_q;
  logic [7:0] rx_flags_q;
  logic [15:0] rx_cst_q, rx_nb_q;
  logic [16:0] rx_len_q;
  logic rx_done_q, rx_err_q, rx_rdy_q, csum_clr;
  logic [15:0] csum_sum;
  logic [31:0] mem_rd;
  wire rx_take = rx_valid_i & rx_rdy_q;
  wire rx_in_hdr = rx_st_q == NPH_RX_HDR;
  wire hdr_end = rx_take & rx_in_hdr & (rx_idx_q == NPH_HDR_LAST);
  wire rx_end = rx_take & rx_last_i;
  wire [31:0] rx_word = {rx_data_i, rx_asm_q};
  wire in_range = ~rx_in_hdr & (rx_len_q >= {1'b0, rx_cst_q});
  wire [16:0] rx_limit = feat.guest_lro ? MAX_LRO : MAX_STD;
  wire f_dv = (rx_flags_q & NPH_FLG_DATA_VALID) != 8'h00;
  wire f_rsc = (rx_flags_q & NPH_FLG_RSC_INFO) != 8'h00;
  wire f_nc = (rx_flags_q & NPH_FLG_NEEDS_CSUM) != 8'h00;
  wire nb_bad = feat.mrg_rxbuf ? (rx_nb_q == 16'h0000) : (rx_nb_q != NPH_NUMBUF_ONE);
  wire fl_bad = ((f_dv | f_nc) & ~feat.guest_csum) | (f_rsc & ~feat.rsc_ext);
  wire len_bad = (rx_len_q + 17'd1) > rx_limit;
  wire rx_bad = rx_in_hdr | nb_bad | fl_bad | len_bad;
  // start/offset are a checksum recipe only when coalescing info is absent
  wire csum_use = f_nc & ~f_rsc;
  wire rx_done_d = rx_end | (rx_done_q & ~cmd_rxclr);
  assign csum_clr = hdr_end;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_q <= NPH_RX_HDR;
      rx_idx_q <= 4'h0;
      rx_asm_q <= 24'h000000;
      rx_flags_q <= 8'h00;
      rx_cst_q <= 16'h0000;
      rx_nb_q <= 16'h0000;
      rx_len_q <= 17'h00000;
      rx_done_q <= 1'b0;
      rx_err_q <= 1'b0;
      rx_rdy_q <= 1'b0;
    end else if (ce_i) begin
      // a finished packet holds the link until software clears it; set wins
      rx_done_q <= rx_done_d;
      rx_rdy_q <= ~rx_done_d;
      if (rx_end) rx_err_q <= rx_bad;
      else if (cmd_rxclr) rx_err_q <= 1'b0;
      if (rx_take && rx_in_hdr) begin
        rx_asm_q <= rx_word[31:8];
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0) rx_flags_q <= rx_data_i;
        if (rx_idx_q == 4'h7) rx_cst_q <= rx_word[31:16];
        if (rx_idx_q == NPH_HDR_LAST) rx_nb_q <= rx_word[31:16];
      end
      if (rx_end) begin
        rx_st_q <= NPH_RX_HDR;
        rx_idx_q <= 4'h0;
      end else if (hdr_end) begin
        rx_st_q <= NPH_RX_PAY;
        rx_len_q <= 17'h00000;
      end else if (rx_take && !rx_in_hdr && rx_len_q != 17'h1ffff) begin
        rx_len_q <= rx_len_q + 17'd1;
      end
    end
  end

  nph_hdr_mem #(.AW(2), .DW(32)) u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(rx_take & rx_in_hdr & (rx_idx_q[1:0] == 2'b11)),
    .wa_i(rx_idx_q[3:2]),
    .wd_i(rx_word),
    .re_i(start),
    .ra_i(2'(wb_adr_i[5:2] - 4'h5)),
    .rd_o(mem_rd)
  );

  nph_csum u_csum (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(csum_clr),
    .vld_i(rx_take & in_range),
    .byte_i(rx_data_i),
    .sum_o(csum_sum)
  );

  // register reads
  wire is_rxw = (adr_q == NPH_REG_RXA) | (adr_q == NPH_REG_RXB) | (adr_q == NPH_REG_RXC);
  wire [31:0] stat = {27'h0000000, csum_use, rx_err_q, rx_done_q, tx_err_q, tx_st_q != NPH_TX_IDLE};
  wire [31:0] rd_mux = (adr_q == NPH_REG_FEAT) ? feat_q
                     : (adr_q == NPH_REG_TXF) ? txf_q
                     : (adr_q == NPH_REG_TXG) ? txg_q
                     : (adr_q == NPH_REG_TXC) ? txc_q
                     : (adr_q == NPH_REG_CMD) ? stat
                     : is_rxw ? mem_rd
                     : (adr_q == NPH_REG_RXS) ? {16'h0000, csum_sum}
                     : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      ack_q <= 1'b0;
      adr_q <= 6'h00;
      dat_q <= 32'h00000000;
      feat_q <= {23'h000000, NPH_FEAT_RST};
      txf_q <= 32'h00000000;
      txg_q <= 32'h00000000;
      txc_q <= 32'h00000000;
      tx_err_q <= 1'b0;
    end else if (ce_i) begin
      pend_q <= start;
      ack_q <= pend_q;
      if (start) adr_q <= wb_adr_i;
      if (pend_q) dat_q <= wb_we_i ? 32'h00000000 : rd_mux;
      if (wr && adr_q == NPH_REG_FEAT) feat_q <= {23'h000000, feat_wr[8:0]};
      if (wr && adr_q == NPH_REG_TXF) txf_q <= nph_lane(txf_q, wb_dat_i, wb_sel_i);
      if (wr && adr_q == NPH_REG_TXG) txg_q <= nph_lane(txg_q, wb_dat_i, wb_sel_i);
      if (wr && adr_q == NPH_REG_TXC) txc_q <= nph_lane(txc_q, wb_dat_i, wb_sel_i);
      // a refused start wins over a clear in the same write
      if (cmd_go && !go_ok) tx_err_q <= 1'b1;
      else if (cmd_txclr) tx_err_q <= 1'b0;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign tx_data_o = tx_dat_q;
  assign tx_valid_o = tx_vld_q;
  assign tx_last_o = tx_lst_q;
  assign pay_ready_o = pay_rdy_q;
  assign rx_ready_o = rx_rdy_q;
endmodule : nph_ctrl

/* tb/nph_ctrl_monitor.sv */
// assertion checker on the packet header controller ports
`timescale 1ns/1ns
module nph_ctrl_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic pay_ready_o,
  input wire logic pay_valid_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic rx_ready_o
);
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic ncs_q;
  logic take;
  assign take = tx_valid_o && tx_ready_i;
  // header byte index, parked at 12 while payload flows
  assign idx_d = !take ? idx_q : tx_last_o ? 4'h0 : (idx_q == 4'hc) ? idx_q : idx_q + 4'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q <= 4'h0;
      ncs_q <= 1'b0;
    end else if (ce_i) begin
      idx_q <= idx_d;
      if (take && idx_q == 4'h0) begin
        ncs_q <= tx_data_o[0];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  // frozen clock enable would hold every output, so those cycles are skipped
  default disable iff (rst_i || !ce_i);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_timely: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[2:3] wb_ack_o)
    else $error("ack late");
  a_reset_quiet: assert property ($past(rst_i) |-> !tx_valid_o && !pay_ready_o && !rx_ready_o && !wb_ack_o)
    else $error("outputs active after reset");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("tx byte changed before taken");
  // an unanswered window may stay open; only a taken byte must close it
  a_pay_pulse: assert property (pay_ready_o && pay_valid_i |=> !pay_ready_o)
    else $error("payload accept wider than a cycle");
  a_flags_clean: assert property (tx_valid_o && idx_q == 4'h0 |-> tx_data_o[7:1] == 7'h00)
    else $error("flags byte carries extra bits");
  a_numbuf_zero: assert property (tx_valid_o && idx_q inside {4'ha, 4'hb} |-> tx_data_o == 8'h00)
    else $error("tx buffer count not zero");
  a_csum_quiet: assert property (tx_valid_o && !ncs_q && idx_q inside {[4'h6:4'h9]} |-> tx_data_o == 8'h00)
    else $error("checksum fields sent without flag");
  a_last_after_hdr: assert property (tx_valid_o && tx_last_o |-> idx_q == 4'hc)
    else $error("last byte inside header");
  a_rx_stop: assert property (rx_valid_i && rx_ready_o && rx_last_i |=> !rx_ready_o)
    else $error("rx ready after frame end");
endmodule : nph_ctrl_monitor

/* tb/nph_dev_model.sv */
// device model: takes transmit bytes with random stalls, plays receive frames
`timescale 1ns/1ns
module nph_dev_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_last_o,
  input wire logic rx_ready_i
);
  logic [8:0] txq[$];
  initial begin
    tx_ready_o = 1'b0;
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
  end
  // bytes kept as given: unknown flags, stale checksum fields and the length hint are not judged
  always @(posedge clk_i) begin
    tx_ready_o <= !rst_i && ($urandom_range(3) != 0);
    if (!rst_i && tx_valid_i && tx_ready_o) begin
      txq.push_back({tx_last_i, tx_data_i});
    end
  end
  // one buffer: header, then the packet straight after it
  task automatic send(input logic [7:0] p[$]);
    for (int i = 0; i < p.size(); i++) begin
      rx_data_o <= p[i];
      rx_valid_o <= 1'b1;
      rx_last_o <= (i == p.size() - 1);
      do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    end
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    // released line shows the inverse so a stale byte cannot pass
    rx_data_o <= ~p[p.size() - 1];
  endtask : send
endmodule : nph_dev_model

/* tb/nph_ctrl_tb.sv */
// self-checking bench for the packet header controller
`timescale 1ns/1ns
module nph_ctrl_tb
  import nph_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [7:0] pay_data_i = 8'h00;
  logic pay_valid_i = 1'b0;
  logic pay_last_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic [31:0] rdat;
  logic [7:0] tx_data_o;
  logic [7:0] rx_data_i;
  logic wb_ack_o, tx_valid_o, tx_last_o, tx_ready_i, pay_ready_o, rx_valid_i, rx_last_i, rx_ready_o;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  // refusals: features, flags, gso type, packet length, segment size
  localparam logic [63:0] TXBAD [10] = '{64'h0000_01_00_0040_0000, 64'h001d_01_01_0040_0100,
    64'h0017_01_03_0040_0100, 64'h001b_01_04_0040_0100, 64'h0001_01_01_0040_0100, 64'h001f_00_01_0040_0100,
    64'h001f_01_01_0040_0000, 64'h000f_01_81_0040_0100, 64'h001f_01_83_0040_0100, 64'h001f_00_00_0029_0000};
  // receive: error, features, flags, buffer count, payload length
  localparam logic [39:0] RXTAB [10] = '{40'h0_020_01_01_14, 40'h0_020_02_01_09, 40'h1_000_02_01_09,
    40'h1_020_00_02_09, 40'h1_080_00_00_09, 40'h0_080_00_03_09, 40'h1_020_05_01_09, 40'h0_120_05_01_09,
    40'h1_000_00_01_29, 40'h0_040_00_01_29};
  localparam logic [7:0] GTAB [4] = '{NPH_GSO_NONE, NPH_GSO_TCPV4, NPH_GSO_UDP, NPH_GSO_TCPV6};
  always #4 clk_i = ~clk_i;
  // small length limits keep oversize frames short
  nph_ctrl #(.MAX_STD(17'd40), .MAX_LRO(17'd60)) u_nph_ctrl (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_data_o, .tx_valid_o, .tx_last_o,
    .tx_ready_i, .pay_data_i, .pay_valid_i, .pay_last_i, .pay_ready_o, .rx_data_i, .rx_valid_i, .rx_last_i,
    .rx_ready_o);
  nph_dev_model u_nph_dev_model (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
    .rx_last_o(rx_last_i), .rx_ready_i(rx_ready_o));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  function automatic logic [15:0] ocs(input logic [7:0] q[$], input int st);
    logic [31:0] s;
    s = 32'h0;
    for (int i = st; i < q.size(); i += 2) begin
      s += {q[i], (i + 1 < q.size()) ? q[i + 1] : 8'h00};
    end
    while (s[31:16] != 16'h0) begin
      s = s[15:0] + s[31:16];
    end
    return ~s[15:0];
  endfunction : ocs
  task automatic tx_pkt(input nph_hdr_s h, input logic [15:0] plen, input int n, input logic bad);
    logic [95:0] e;
    logic [8:0] x[$];
    e = h;
    e[7:1] = 7'h00;
    if (!h.flags[0]) e[79:48] = 32'h0;
    e[95:80] = NPH_NUMBUF_TX;
    for (int i = 0; i < 12; i++) x.push_back({1'b0, e[8*i +: 8]});
    u_nph_dev_model.txq.delete();
    wb(1'b1, NPH_REG_TXF, h[31:0], 4'hf);
    wb(1'b1, NPH_REG_TXG, {plen, h.gso_size}, 4'hf);
    wb(1'b1, NPH_REG_TXC, h[79:48], 4'hf);
    wb(1'b1, NPH_REG_CMD, 32'h1, 4'hf);
    for (int i = 0; i < n && !bad; i++) begin
      x.push_back({i == n - 1, 8'($urandom)});
      pay_data_i <= x[12 + i][7:0];
      pay_valid_i <= 1'b1;
      pay_last_i <= (i == n - 1);
      do @(posedge clk_i); while (pay_ready_o !== 1'b1);
    end
    pay_valid_i <= 1'b0;
    pay_last_i <= 1'b0;
    do wb(1'b0, NPH_REG_CMD, 32'h0, 4'hf); while (rdat[0] !== 1'b0);
    chk(32'(rdat[1]), 32'(bad), "tx refusal");
    while (!bad && u_nph_dev_model.txq.size() < 12 + n) @(posedge clk_i);
    chk(32'(u_nph_dev_model.txq.size()), bad ? 32'd0 : 32'(12 + n), "tx count");
    for (int i = 0; i < 12 + n && !bad; i++) chk(32'(u_nph_dev_model.txq[i]), 32'(x[i]), "tx byte");
    wb(1'b1, NPH_REG_CMD, 32'h4, 4'hf);
  endtask : tx_pkt
  initial begin
    logic [95:0] e;
    logic [63:0] t;
    logic [39:0] r;
    logic [7:0] p[$];
    nph_hdr_s h;
    void'($urandom(32'ha9e88715));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, NPH_REG_FEAT, 32'h0, 4'hf);
    chk(rdat, {23'h0, NPH_FEAT_RST}, "feature reset");
    wb(1'b1, 6'h3c, 32'hffffffff, 4'hf);
    wb(1'b0, 6'h3c, 32'h0, 4'hf);
    chk(rdat, 32'h0, "unmapped read");
    wb(1'b1, NPH_REG_FEAT, 32'h1ff, 4'h2);
    wb(1'b0, NPH_REG_FEAT, 32'h0, 4'hf);
    chk(rdat, 32'h100, "lane write");
    ce_i <= 1'b0;
    fork
      wb(1'b1, NPH_REG_FEAT, 32'h1f, 4'hf);
      begin
        repeat (6) @(posedge clk_i);
        chk(32'(wb_ack_o), 32'h0, "ack while frozen");
        ce_i <= 1'b1;
      end
    join
    wb(1'b0, NPH_REG_FEAT, 32'h0, 4'hf);
    chk(rdat, 32'h1f, "write after freeze");
    for (int k = 0; k < 6; k++) begin
      h = nph_hdr_s'({$urandom, $urandom, $urandom});
      h.gso_type = GTAB[k % 4] | ((k == 5) ? NPH_GSO_ECN : 8'h00);
      h.flags[0] = (h.gso_type != NPH_GSO_NONE) || (k == 4);
      h.gso_size[0] = 1'b1;
      // unsegmented length sits exactly on the bench's standard limit
      tx_pkt(h, (h.gso_type == NPH_GSO_NONE) ? 16'd40 : 16'd1600, k + 1, 1'b0);
    end
    for (int k = 0; k < 10; k++) begin
      t = TXBAD[k];
      h = '0;
      h.flags = t[47:40];
      h.gso_type = t[39:32];
      h.gso_size = t[15:0];
      wb(1'b1, NPH_REG_FEAT, {16'h0, t[63:48]}, 4'hf);
      tx_pkt(h, t[31:16], 1, 1'b1);
    end
    for (int k = 0; k < 10; k++) begin
      r = RXTAB[k];
      h = nph_hdr_s'({$urandom, $urandom, $urandom});
      h.flags = r[23:16];
      h.gso_type = NPH_GSO_NONE;
      h.num_buffers = {8'h00, r[15:8]};
      h.csum_start = 16'($urandom_range(r[7:0] - 8'h01));
      e = h;
      p.delete();
      for (int i = 0; i < 12 + r[7:0]; i++) p.push_back((i < 12) ? e[8*i +: 8] : 8'($urandom));
      wb(1'b1, NPH_REG_FEAT, {20'h0, r[35:24]}, 4'hf);
      u_nph_dev_model.send(p);
      do wb(1'b0, NPH_REG_CMD, 32'h0, 4'hf); while (rdat[2] !== 1'b1);
      chk(32'(rdat[3:2]), {30'h0, r[36], 1'b1}, "rx status");
      if (!r[36]) chk(32'(rdat[4]), 32'(r[16] & !r[18]), "checksum use");
      for (int j = 0; j < 3; j++) begin
        wb(1'b0, NPH_REG_RXA + 6'(4 * j), 32'h0, 4'hf);
        chk(rdat, e[32*j +: 32], "rx header word");
      end
      if (!r[36] && r[16] && !r[18]) begin
        wb(1'b0, NPH_REG_RXS, 32'h0, 4'hf);
        chk(32'(rdat[15:0]), 32'(ocs(p[12:$], int'(h.csum_start))), "rx checksum");
      end
      wb(1'b1, NPH_REG_CMD, 32'h2, 4'hf);
      wb(1'b0, NPH_REG_CMD, 32'h0, 4'hf);
      chk(32'(rdat[2]), 32'h0, "rx done cleared");
    end
    report_and_stop();
  end
endmodule : nph_ctrl_tb
bind nph_ctrl nph_ctrl_monitor u_nph_ctrl_monitor (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .tx_data_o, .tx_valid_o, .tx_last_o, .tx_ready_i, .pay_ready_o, .pay_valid_i, .rx_valid_i, .rx_last_i,
  .rx_ready_o);
